// >>> inc/tsri_consts.svh
// constants for the transmit-status and route-information framer
`ifndef TSRI_CONSTS_SVH
`define TSRI_CONSTS_SVH

// ****************************************************************
// frame layout
// ****************************************************************
`define TSRI_START_DELIM   8'h7e
`define TSRI_TYPE_XST      8'h8b
`define TSRI_TYPE_RTI      8'h8d
`define TSRI_XST_RSVD      16'hfffe
`define TSRI_EV_NACK       8'h11
`define TSRI_EV_TRACE      8'h12
`define TSRI_RTI_RSVD      8'h00
`define TSRI_LEN_HI        8'h00
`define TSRI_LEN_XST       8'h07
`define TSRI_LEN_RTI       8'h2a
`define TSRI_RTI_DLEN      8'h27
`define TSRI_HDR_BYTES     6'h03
`define TSRI_IDX_LEN_HI    6'h01
`define TSRI_IDX_LEN_LO    6'h02
`define TSRI_IDX_TYPE      6'h03
`define TSRI_IDX_ID        6'h04
`define TSRI_IDX_RSVD_HI   6'h05
`define TSRI_IDX_RSVD_LO   6'h06
`define TSRI_IDX_DELIV     6'h08
`define TSRI_IDX_DISC      6'h09
`define TSRI_CKSUM_BASE    8'hff
`define TSRI_PAYLOAD_W     336
`define TSRI_XST_W         56

// ****************************************************************
// status codes
// ****************************************************************
`define TSRI_DLV_SUCCESS   8'h00
`define TSRI_DLV_MAC_ACK   8'h01
`define TSRI_DLV_CCA       8'h02
`define TSRI_DLV_SPECTRUM  8'h03
`define TSRI_DLV_NET_ACK   8'h21
`define TSRI_DLV_NO_ROUTE  8'h25
`define TSRI_DLV_INTERNAL  8'h31
`define TSRI_DLV_RESOURCE  8'h32
`define TSRI_DLV_NO_SESS   8'h34
`define TSRI_DLV_ENCRYPT   8'h35
`define TSRI_DLV_TOO_LARGE 8'h74
`define TSRI_DLV_UNREQ     8'h75
`define TSRI_DISC_NONE     8'h00
`define TSRI_DISC_ROUTE    8'h02

// ****************************************************************
// register map and timing
// ****************************************************************
`define TSRI_ADDR_CTRL     8'h00
`define TSRI_ADDR_STAT     8'h04
`define TSRI_ADDR_COUNT    8'h08
`define TSRI_ADDR_TIMER    8'h0c
`define TSRI_CTRL_EN_RST   1'b1
`define TSRI_CLK_NS        50
`define TSRI_US_NS         1000
`define TSRI_US_CYCLES     (`TSRI_US_NS / `TSRI_CLK_NS)

`endif

// >>> inc/tsri_pkg.sv
// types shared by the framer and its checksum accumulator
package tsri_pkg;
  `include "tsri_consts.svh"

  typedef enum logic {TSRI_IDLE, TSRI_SEND} tsri_phase_t;
  typedef enum logic {TSRI_KIND_XST, TSRI_KIND_RTI} tsri_kind_t;

  typedef struct packed {
    tsri_phase_t                  phase;
    tsri_kind_t                   kind;
    logic [`TSRI_PAYLOAD_W-1:0]   payload;
    logic [7:0]                   len;
    logic [5:0]                   idx;
    logic [7:0]                   outData;
    logic                         outValid;
    logic                         xstRdy;
    logic                         rtiRdy;
    logic                         turn;
    logic [31:0]                  usTimer;
    logic [4:0]                   usDiv;
    logic                         enable;
    logic [15:0]                  sentCnt;
    logic [15:0]                  dropCnt;
    logic [31:0]                  rdData;
  } tsri_state_t;

  typedef struct packed {
    logic [7:0] sum;
  } tsri_cksum_state_t;
endpackage

// >>> hw/tsri_cksum.sv
// running 8-bit sum of the bytes that the checksum covers
`timescale 1ns/1ns
module tsri_cksum
  import tsri_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // accumulate control
  input  wire logic       clr,
  input  wire logic       add,
  input  wire logic [7:0] dataIn,
  // running sum
  output logic [7:0]      sum
);

  tsri_cksum_state_t st_r;
  tsri_cksum_state_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (clr) begin
      st_nxt.sum = 8'h00;
    end else if (add) begin
      st_nxt.sum = 8'(st_r.sum + dataIn);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sum = st_r.sum;

endmodule

// >>> hw/tsri_framer.sv
// serial framer for extended transmit-status and route-information frames
// Function
// - finished network transmit request yields a status frame of type 0x8B.
// - status frame suppressed when the request frame identifier is zero.
// - broadcast requests always report delivery status 0x00.
// - frame starts with delimiter, then 16-bit length counting bytes between length field and checksum.
// - status frame carries the request frame identifier at offset 4.
// - status frame carries unused 16-bit field 0xFFFE at offset 5.
// - status frame carries the 8-bit retry count at offset 7.
// - delivery status byte at offset 8 uses the documented code set.
// - discovery byte at offset 9 is 0x00, or 0x02 after route discovery.
// - checksum is 0xFF minus low byte of sum from offset 3.
// - unicast trace-route or NACK request yields a route frame of type 0x8D.
// - route frame source event is 0x11 for NACK, 0x12 for trace.
// - route frame offset 5 counts following bytes, checksum excluded.
// - route frame carries 32-bit microsecond timer at offset 6.
// - route frame carries MAC acknowledgement timeout count at offset 10.
// - route frame carries blocked-by-reception count at offset 11.
// - route frame carries destination and originator 64-bit addresses.
// - route frame carries responder and next-hop receiver 64-bit addresses.
// - delivery codes 0x34 no secure session and 0x35 encryption failure.
`timescale 1ns/1ns
`include "tsri_consts.svh"
module tsri_framer
  import tsri_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // register port
  input  wire logic [7:0]  regAddr,
  input  wire logic [31:0] regWrData,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic [31:0]      regRdData,
  // transmit completion event
  input  wire logic        xstValid,
  input  wire logic [7:0]  xstFrameId,
  input  wire logic        xstBroadcast,
  input  wire logic [7:0]  xstRetries,
  input  wire logic [7:0]  xstDelivery,
  input  wire logic        xstRouteDisc,
  output logic             xstReady,
  // route diagnostics event
  input  wire logic        rtiValid,
  input  wire logic        rtiNack,
  input  wire logic [7:0]  rtiAckTimeouts,
  input  wire logic [7:0]  rtiBlocked,
  input  wire logic [63:0] rtiDestAddr,
  input  wire logic [63:0] rtiSrcAddr,
  input  wire logic [63:0] rtiRespAddr,
  input  wire logic [63:0] rtiRecvAddr,
  output logic             rtiReady,
  // serial byte stream to the host
  output logic [7:0]       txByte,
  output logic             txByteValid,
  input  wire logic        txByteReady
);

  localparam int PW = `TSRI_PAYLOAD_W;

  tsri_state_t st_r;
  tsri_state_t st_nxt;

  logic [7:0]    ckSum;
  logic          ckClr;
  logic          ckAdd;
  logic [7:0]    nextByte;
  logic [5:0]    nextIdx;
  logic [5:0]    lastIdx;
  logic [PW-1:0] shifted;
  logic          handshake;
  logic          takeXst;
  logic          takeRti;
  logic [7:0]    delivery;
  logic [7:0]    discovery;
  logic [7:0]    eventCode;

  // ****************************************************************
  // byte selection
  // ****************************************************************
  assign handshake = st_r.outValid && txByteReady;
  assign lastIdx   = 6'(st_r.len) + `TSRI_HDR_BYTES;
  assign nextIdx   = st_r.idx + 6'h01;
  assign takeXst   = (st_r.phase == TSRI_IDLE) && xstValid && st_r.xstRdy;
  assign takeRti   = (st_r.phase == TSRI_IDLE) && rtiValid && st_r.rtiRdy;

  // broadcasts are never acknowledged, so they read as delivered
  assign delivery  = xstBroadcast ? `TSRI_DLV_SUCCESS : xstDelivery;
  assign discovery = xstRouteDisc ? `TSRI_DISC_ROUTE : `TSRI_DISC_NONE;
  assign eventCode = rtiNack ? `TSRI_EV_NACK : `TSRI_EV_TRACE;

  always_comb begin
    shifted  = st_r.payload << {nextIdx - `TSRI_HDR_BYTES, 3'b000};
    nextByte = shifted[PW-1 -: 8];
    ckAdd    = 1'b0;
    if (nextIdx == `TSRI_IDX_LEN_HI) begin
      nextByte = `TSRI_LEN_HI;
    end else if (nextIdx == `TSRI_IDX_LEN_LO) begin
      nextByte = st_r.len;
    end else if (nextIdx == lastIdx) begin
      nextByte = 8'(`TSRI_CKSUM_BASE - ckSum);
    end else begin
      ckAdd = handshake && (st_r.phase == TSRI_SEND) && (st_r.idx != lastIdx);
    end
  end

  assign ckClr = takeXst || takeRti;

  tsri_cksum u_cksum (
    .clk    (clk),
    .rst    (rst),
    .clr    (ckClr),
    .add    (ckAdd),
    .dataIn (nextByte),
    .sum    (ckSum)
  );

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    st_nxt = st_r;

    // free-running microsecond timer, wraps after about 71 minutes
    if (st_r.usDiv == 5'(`TSRI_US_CYCLES - 1)) begin
      st_nxt.usDiv   = 5'h00;
      st_nxt.usTimer = st_r.usTimer + 32'h1;
    end else begin
      st_nxt.usDiv = st_r.usDiv + 5'h01;
    end

    if (regWr && (regAddr == `TSRI_ADDR_CTRL)) begin
      st_nxt.enable = regWrData[0];
    end

    st_nxt.rdData = 32'h0;
    if (regRd) begin
      unique case (regAddr)
        `TSRI_ADDR_CTRL:  st_nxt.rdData = {31'h0, st_r.enable};
        `TSRI_ADDR_STAT:  st_nxt.rdData = {30'h0, st_r.kind == TSRI_KIND_RTI, st_r.phase == TSRI_SEND};
        `TSRI_ADDR_COUNT: st_nxt.rdData = {st_r.dropCnt, st_r.sentCnt};
        `TSRI_ADDR_TIMER: st_nxt.rdData = st_r.usTimer;
        default:          st_nxt.rdData = 32'h0;
      endcase
    end

    unique case (st_r.phase)
      TSRI_IDLE: begin
        // the two sources take turns so that valid-and-ready always means taken
        st_nxt.turn = ~st_r.turn;
        if (takeXst) begin
          if (xstFrameId == 8'h00) begin
            st_nxt.dropCnt = st_r.dropCnt + 16'h1;
          end else begin
            st_nxt.phase    = TSRI_SEND;
            st_nxt.kind     = TSRI_KIND_XST;
            st_nxt.len      = `TSRI_LEN_XST;
            st_nxt.payload  = {`TSRI_TYPE_XST, xstFrameId, `TSRI_XST_RSVD,
                               xstRetries, delivery, discovery,
                               {(PW - `TSRI_XST_W){1'b0}}};
            st_nxt.idx      = 6'h00;
            st_nxt.outData  = `TSRI_START_DELIM;
            st_nxt.outValid = 1'b1;
          end
        end else if (takeRti) begin
          st_nxt.phase    = TSRI_SEND;
          st_nxt.kind     = TSRI_KIND_RTI;
          st_nxt.len      = `TSRI_LEN_RTI;
          st_nxt.payload  = {`TSRI_TYPE_RTI, eventCode, `TSRI_RTI_DLEN,
                             st_r.usTimer,
                             rtiAckTimeouts, rtiBlocked,
                             `TSRI_RTI_RSVD,
                             rtiDestAddr, rtiSrcAddr,
                             rtiRespAddr, rtiRecvAddr};
          st_nxt.idx      = 6'h00;
          st_nxt.outData  = `TSRI_START_DELIM;
          st_nxt.outValid = 1'b1;
        end
      end
      TSRI_SEND: begin
        if (handshake) begin
          if (st_r.idx == lastIdx) begin
            st_nxt.phase    = TSRI_IDLE;
            st_nxt.outValid = 1'b0;
            st_nxt.sentCnt  = st_r.sentCnt + 16'h1;
          end else begin
            st_nxt.idx     = nextIdx;
            st_nxt.outData = nextByte;
          end
        end
      end
    endcase

    st_nxt.xstRdy = (st_nxt.phase == TSRI_IDLE) && st_nxt.enable && !st_nxt.turn;
    st_nxt.rtiRdy = (st_nxt.phase == TSRI_IDLE) && st_nxt.enable && st_nxt.turn;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= '{phase: TSRI_IDLE, kind: TSRI_KIND_XST, enable: `TSRI_CTRL_EN_RST, default: '0};
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign regRdData   = st_r.rdData;
  assign xstReady    = st_r.xstRdy;
  assign rtiReady    = st_r.rtiRdy;
  assign txByte      = st_r.outData;
  assign txByteValid = st_r.outValid;

  // ****************************************************************
  // checks
  // ****************************************************************
  start_delim_a: assert property (@(posedge clk) disable iff (rst)
    (txByteValid && !$past(txByteValid)) |-> (txByte == `TSRI_START_DELIM))
    else $error("frame did not open with the start delimiter");

  zero_id_a: assert property (@(posedge clk) disable iff (rst)
    (xstValid && xstReady && xstFrameId == 8'h00 && !txByteValid) |=> !txByteValid)
    else $error("status frame sent for a zero frame identifier");

  id_copy_a: assert property (@(posedge clk) disable iff (rst)
    (xstValid && xstReady && xstFrameId != 8'h00)
      |=> (st_r.payload[PW-9 -: 8] == $past(xstFrameId)) && (st_r.payload[PW-1 -: 8] == `TSRI_TYPE_XST))
    else $error("status frame lost the frame identifier or type");

  bcast_ok_a: assert property (@(posedge clk) disable iff (rst)
    (xstValid && xstReady && xstBroadcast && xstFrameId != 8'h00)
      |=> st_r.payload[PW-41 -: 8] == `TSRI_DLV_SUCCESS)
    else $error("broadcast reported a delivery failure");

  xst_rsvd_a: assert property (@(posedge clk) disable iff (rst)
    (txByteValid && st_r.kind == TSRI_KIND_XST && st_r.idx == `TSRI_IDX_RSVD_HI) |->
      (txByte == `TSRI_XST_RSVD >> 8))
    else $error("unused status field high byte wrong");

  len_lo_a: assert property (@(posedge clk) disable iff (rst)
    (txByteValid && st_r.idx == `TSRI_IDX_LEN_LO) |->
      (txByte == ((st_r.kind == TSRI_KIND_XST) ? `TSRI_LEN_XST : `TSRI_LEN_RTI)))
    else $error("length field does not match frame kind");

  rti_event_a: assert property (@(posedge clk) disable iff (rst)
    (rtiValid && rtiReady) |=>
      (st_r.payload[PW-9 -: 8] == ($past(rtiNack) ? `TSRI_EV_NACK : `TSRI_EV_TRACE)) &&
      (st_r.payload[PW-1 -: 8] == `TSRI_TYPE_RTI))
    else $error("route frame source event wrong");

  cksum_sum_a: assert property (@(posedge clk) disable iff (rst)
    (txByteValid && st_r.idx == lastIdx) |-> (8'(txByte + ckSum) == `TSRI_CKSUM_BASE))
    else $error("checksum does not close the byte sum to 0xff");

  hold_byte_a: assert property (@(posedge clk) disable iff (rst)
    (txByteValid && !txByteReady) |=> (txByteValid && $stable(txByte) && $stable(st_r.idx)))
    else $error("byte changed while the host stalled");

  frame_len_a: assert property (@(posedge clk) disable iff (rst)
    (txByteValid && txByteReady && st_r.idx == lastIdx) |=> !txByteValid && (st_r.phase == TSRI_IDLE))
    else $error("frame did not end after its checksum");

endmodule

// >>> tb/tsri_host_model.sv
// behavioural host that receives frames from the framer and checks framing and checksum
`timescale 1ns/1ns
module tsri_host_model
  import tsri_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // byte stream from the framer
  input  wire logic [7:0] txByte,
  input  wire logic       txByteValid,
  output logic            txByteReady,
  // pacing: slow mode takes one byte in four
  input  wire logic       stallEn
);
  logic [7:0] frm [0:63];
  logic [7:0] sum;
  logic [1:0] pace;
  int         nBytes;
  int         nFrames;
  int         nBad;
  int         fLen;

  always_ff @(posedge clk) begin
    if (rst) begin
      txByteReady <= 1'b0;
      pace        <= 2'h0;
      sum         <= 8'h00;
      nBytes      <= 0;
      nFrames     <= 0;
      nBad        <= 0;
      fLen        <= 0;
    end else begin
      pace        <= pace + 2'h1;
      txByteReady <= !stallEn || (pace == 2'h3);
      if (txByteValid && txByteReady) begin
        frm[nBytes] <= txByte;
        nBytes      <= nBytes + 1;
        if (nBytes == 0 && txByte !== 8'h7e) begin
          nBad <= nBad + 1;
        end
        sum <= (nBytes < 3) ? 8'h00 : sum + txByte;
        // the end is found from the length field alone, so a longer data count is accepted
        if (nBytes > 3 && nBytes == {frm[1], frm[2]} + 3) begin
          if (sum + txByte !== 8'hff) begin
            nBad <= nBad + 1;
          end
          nFrames <= nFrames + 1;
          fLen    <= nBytes + 1;
          nBytes  <= 0;
        end
      end
    end
  end
endmodule

// >>> tb/test_tsri_framer.sv
// self-checking bench for the status and route-information framer
`timescale 1ns/1ns
module test_tsri_framer
  import tsri_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  regAddr = 8'h00;
  logic [31:0] regWrData = 32'h0;
  logic        regWr = 1'b0;
  logic        regRd = 1'b0;
  logic [31:0] regRdData;
  logic        xstValid = 1'b0;
  logic [7:0]  xstFrameId = 8'h00;
  logic        xstBroadcast = 1'b0;
  logic [7:0]  xstRetries = 8'h00;
  logic [7:0]  xstDelivery = 8'h00;
  logic        xstRouteDisc = 1'b0;
  logic        xstReady;
  logic        rtiValid = 1'b0;
  logic        rtiNack = 1'b0;
  logic [7:0]  rtiAckTimeouts = 8'h00;
  logic [7:0]  rtiBlocked = 8'h00;
  logic [63:0] rtiAddr [4] = '{64'h0, 64'h0, 64'h0, 64'h0};
  logic        rtiReady;
  logic [7:0]  txByte;
  logic        txByteValid;
  logic        txByteReady;
  logic        stallEn = 1'b0;
  int          nMismatch = 0;
  int          totalChecks = 0;
  int          cycles = 0;
  int          nFr = 0;
  int          nDrop = 0;
  logic [7:0]  exp [$];
  logic [7:0]  codes [12] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h21, 8'h25, 8'h31, 8'h32, 8'h34, 8'h35, 8'h74, 8'h75};

  always #25 clk = ~clk;

  tsri_framer i_tsri_framer (
    .clk(clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .xstValid(xstValid), .xstFrameId(xstFrameId), .xstBroadcast(xstBroadcast),
    .xstRetries(xstRetries), .xstDelivery(xstDelivery), .xstRouteDisc(xstRouteDisc), .xstReady(xstReady),
    .rtiValid(rtiValid), .rtiNack(rtiNack), .rtiAckTimeouts(rtiAckTimeouts), .rtiBlocked(rtiBlocked),
    .rtiDestAddr(rtiAddr[0]), .rtiSrcAddr(rtiAddr[1]), .rtiRespAddr(rtiAddr[2]), .rtiRecvAddr(rtiAddr[3]),
    .rtiReady(rtiReady), .txByte(txByte), .txByteValid(txByteValid), .txByteReady(txByteReady));

  tsri_host_model i_tsri_host_model (
    .clk(clk), .rst(rst), .txByte(txByte), .txByteValid(txByteValid), .txByteReady(txByteReady),
    .stallEn(stallEn));

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic check(input logic [63:0] seen, input logic [63:0] want);
    totalChecks++;
    if (seen !== want) begin
      nMismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, want);
    end
  endtask

  task automatic complete_run();
    if (nMismatch == 0 && totalChecks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // a hang shows up as a counted mismatch and an ordinary verdict
  always @(posedge clk) begin
    cycles++;
    if (cycles == 10000) begin
      nMismatch++;
      complete_run();
    end
  end

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr   <= a;
    regWrData <= d;
    regWr     <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1 d = regRdData;
  endtask

  task automatic chk_reg(input logic [7:0] a, input logic [31:0] want);
    logic [31:0] d;
    reg_rd(a, d);
    check(d, want);
  endtask

  task automatic take(input logic isRti);
    int i;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while ((isRti ? rtiReady : xstReady) !== 1'b1 && i < 100);
    check(isRti ? rtiReady : xstReady, 1'b1);
    xstValid <= 1'b0;
    rtiValid <= 1'b0;
  endtask

  task automatic wait_frame();
    int i;
    i = 0;
    nFr++;
    while (i_tsri_host_model.nFrames < nFr && i < 3000) begin
      @(posedge clk);
      i++;
    end
    check(i_tsri_host_model.nFrames, nFr);
  endtask

  task automatic cmp_frame();
    logic [7:0] s;
    s = 8'h00;
    for (int k = 3; k < exp.size(); k++) s += exp[k];
    exp.push_back(8'hff - s);
    check(i_tsri_host_model.nBad, 0);
    check(i_tsri_host_model.fLen, exp.size());
    foreach (exp[k]) check(i_tsri_host_model.frm[k], exp[k]);
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic send_xst(input logic [7:0] id, rt, dl, input logic bc, rd, gate);
    if (gate) begin
      reg_wr(8'h00, 32'h0);
    end
    @(posedge clk);
    xstFrameId   <= id;
    xstRetries   <= rt;
    xstDelivery  <= dl;
    xstBroadcast <= bc;
    xstRouteDisc <= rd;
    xstValid     <= 1'b1;
    if (gate) begin
      // a disabled framer must leave the request waiting
      repeat (20) @(posedge clk);
      check(xstReady, 1'b0);
      check(i_tsri_host_model.nFrames, nFr);
      reg_wr(8'h00, 32'h1);
    end
    take(1'b0);
    if (id == 8'h00) begin
      nDrop++;
      repeat (40) @(posedge clk);
      check(i_tsri_host_model.nFrames, nFr);
    end else begin
      wait_frame();
      exp = '{8'h7e, 8'h00, 8'h07, 8'h8b, id, 8'hff, 8'hfe, rt, bc ? 8'h00 : dl, rd ? 8'h02 : 8'h00};
      cmp_frame();
    end
  endtask

  task automatic send_rti(input logic nack, input logic [7:0] ack, blk, input logic stall);
    logic [31:0] t0;
    logic [31:0] ts;
    reg_rd(8'h0c, t0);
    @(posedge clk);
    rtiNack        <= nack;
    rtiAckTimeouts <= ack;
    rtiBlocked     <= blk;
    stallEn        <= stall;
    for (int a = 0; a < 4; a++) rtiAddr[a] <= {8'(a), 8'h13, 8'ha2, ack, 8'h40, blk, 8'h52, 8'(a + 9)};
    rtiValid <= 1'b1;
    take(1'b1);
    wait_frame();
    ts = {i_tsri_host_model.frm[6], i_tsri_host_model.frm[7], i_tsri_host_model.frm[8], i_tsri_host_model.frm[9]};
    check(ts - t0 <= 32'h2, 1'b1);
    exp = '{8'h7e, 8'h00, 8'h2a, 8'h8d, nack ? 8'h11 : 8'h12, 8'h27, ts[31:24], ts[23:16], ts[15:8], ts[7:0],
            ack, blk, 8'h00};
    for (int a = 0; a < 4; a++) for (int b = 7; b >= 0; b--) exp.push_back(rtiAddr[a][8*b +: 8]);
    cmp_frame();
    stallEn <= 1'b0;
    chk_reg(8'h04, 32'h2);
  endtask

  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    chk_reg(8'h00, 32'h1);
    chk_reg(8'h10, 32'h0);
    chk_reg(8'h08, 32'h0);
    for (int i = 0; i < 12; i++) send_xst(8'(255 - i), 8'(i), codes[i], 1'b0, i[0], 1'b0);
    send_xst(8'h40, 8'h03, 8'h25, 1'b1, 1'b1, 1'b0);
    send_xst(8'h00, 8'h01, 8'h01, 1'b0, 1'b0, 1'b0);
    send_xst(8'h01, 8'h00, 8'h74, 1'b0, 1'b1, 1'b1);
    chk_reg(8'h04, 32'h0);
    send_rti(1'b1, 8'h02, 8'h01, 1'b0);
    send_rti(1'b0, 8'hff, 8'h05, 1'b1);
    chk_reg(8'h08, {16'(nDrop), 16'(nFr)});
    complete_run();
  end
endmodule
